// ---- core/dsrctl_top.sv ----
`timescale 1ns/1ps
module dsrctl_top #(
  parameter int FLOOR_W = 4
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  // register port
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic [7:0]                    reg_rdata,
  output logic                          reg_rvalid,
  // audio path
  input  wire logic                     audio_overrun_event,
  input  wire logic                     audio_underrun_event,
  output logic                          audio_strobe_rising,
  // pixel clock
  output logic                          pclk_from_selftest,
  // link lock and back channel
  input  wire logic                     link_linked,
  input  wire logic                     fwd_video_disabled,
  output logic                          rx_lock,
  output logic                          video_disabled_flag,
  input  wire logic                     back_channel_pin_zero,
  input  wire logic                     back_channel_filtered,
  output logic                          back_channel_out,
  output dsrctl_pkg::dsrctl_mode_e      link_input_mode,
  // equalizer, index 0 is port zero
  input  wire logic [FLOOR_W-1:0]       eq_floor_value_p0,
  input  wire logic [FLOOR_W-1:0]       eq_floor_value_p1,
  output logic [1:0]                    eq_restart,
  output logic [1:0]                    eq_floor_apply,
  output logic [FLOOR_W-1:0]            eq_floor_p0,
  output logic [FLOOR_W-1:0]            eq_floor_p1,
  // strap decoders
  input  wire logic                     strap_zero_valid,
  input  wire dsrctl_pkg::dsrctl_code_t strap_zero_decode,
  input  wire logic                     strap_one_valid,
  input  wire dsrctl_pkg::dsrctl_code_t strap_one_decode
);
  import dsrctl_pkg::*;
  `include "dsrctl_defs.svh"

  dsrctl_strap_if st0 ();
  dsrctl_strap_if st1 ();

  logic         overrun_q;
  logic         underrun_q;
  logic         err_clr_bit_q;
  logic         rising_q;
  logic         pclk_ext_q;
  logic         lock_mode_q;
  logic         raw_bc_q;
  logic [1:0]   mode_q;
  logic         port_one_select_q;
  logic         port_zero_select_q;
  logic [1:0]   eq_restart_bit_q;
  logic [1:0]   eq_override_q;
  logic [1:0]   eq_floor_en_q;
  logic         wr_audio;
  logic         wr_pclk;
  logic         wr_dualrx;
  logic         wr_eq1;
  logic         err_clear;
  logic         rd_port1;
  logic [7:0]   rdata_d;

  // per-port view of the equalizer control byte
  function automatic logic [7:0] eq1_byte(input logic rst,
                                          input logic ovr,
                                          input logic en);
    logic [7:0] b;
    b = 8'h00;
    b[`DSRCTL_EQ_RESTART]  = rst;
    b[`DSRCTL_EQ_OVERRIDE] = ovr;
    b[`DSRCTL_EQ_FLOOR_EN] = en;
    return b;
  endfunction

  dsrctl_strap u_strap0 (
    .clock        (clock),
    .reset_n      (reset_n),
    .decode_valid (strap_zero_valid),
    .decode_code  (strap_zero_decode),
    .st           (st0)
  );

  dsrctl_strap u_strap1 (
    .clock        (clock),
    .reset_n      (reset_n),
    .decode_valid (strap_one_valid),
    .decode_code  (strap_one_decode),
    .st           (st1)
  );

  // write decode
  always_comb begin
    wr_audio  = 1'b0;
    wr_pclk   = 1'b0;
    wr_dualrx = 1'b0;
    wr_eq1    = 1'b0;
    if (reg_write && reg_addr == `DSRCTL_ADDR_AUDIO) begin
      wr_audio = 1'b1;
    end else if (reg_write && reg_addr == `DSRCTL_ADDR_PCLK) begin
      wr_pclk = 1'b1;
    end else if (reg_write && reg_addr == `DSRCTL_ADDR_DUALRX) begin
      wr_dualrx = 1'b1;
    end else if (reg_write && reg_addr == `DSRCTL_ADDR_EQ1) begin
      wr_eq1 = 1'b1;
    end
  end

  assign err_clear = wr_audio && reg_wdata[`DSRCTL_AUD_ERR_CLR];

  // sticky fifo errors, a new event wins over the clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overrun_q  <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      overrun_q  <= audio_overrun_event  | (overrun_q  & ~err_clear);
      underrun_q <= audio_underrun_event | (underrun_q & ~err_clear);
    end
  end

  // audio control writable bits
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      err_clr_bit_q <= 1'(`DSRCTL_RST_AUDIO >> `DSRCTL_AUD_ERR_CLR);
      rising_q      <= 1'(`DSRCTL_RST_AUDIO >> `DSRCTL_AUD_RISING);
    end else if (wr_audio) begin
      err_clr_bit_q <= reg_wdata[`DSRCTL_AUD_ERR_CLR];
      rising_q      <= reg_wdata[`DSRCTL_AUD_RISING];
    end
  end

  // pixel clock test select
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pclk_ext_q <= 1'(`DSRCTL_RST_PCLK >> `DSRCTL_PCLK_EXT);
    end else if (wr_pclk) begin
      pclk_ext_q <= reg_wdata[`DSRCTL_PCLK_EXT];
    end
  end

  // dual receive control, reserved bits dropped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_mode_q <= 1'(`DSRCTL_RST_DUALRX >> `DSRCTL_DRX_LOCK_MODE);
      raw_bc_q    <= 1'(`DSRCTL_RST_DUALRX >> `DSRCTL_DRX_RAW_BC);
      mode_q      <= 2'h0;
      port_one_select_q <= 1'(`DSRCTL_RST_DUALRX >> `DSRCTL_DRX_PORT1);
      port_zero_select_q <= 1'(`DSRCTL_RST_DUALRX >> `DSRCTL_DRX_PORT0);
    end else if (wr_dualrx) begin
      lock_mode_q <= reg_wdata[`DSRCTL_DRX_LOCK_MODE];
      raw_bc_q    <= reg_wdata[`DSRCTL_DRX_RAW_BC];
      mode_q      <= reg_wdata[`DSRCTL_DRX_MODE_HI:`DSRCTL_DRX_MODE_LO];
      port_one_select_q <= reg_wdata[`DSRCTL_DRX_PORT1];
      port_zero_select_q <= reg_wdata[`DSRCTL_DRX_PORT0];
    end
  end

  // per-port equalizer control, each selected port takes the write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eq_restart_bit_q <= 2'h0;
      eq_override_q    <= 2'h0;
      eq_floor_en_q    <= 2'h0;
    end else if (wr_eq1) begin
      if (port_zero_select_q) begin
        eq_restart_bit_q[0] <= reg_wdata[`DSRCTL_EQ_RESTART];
        eq_override_q[0]    <= reg_wdata[`DSRCTL_EQ_OVERRIDE];
        eq_floor_en_q[0]    <= reg_wdata[`DSRCTL_EQ_FLOOR_EN];
      end
      if (port_one_select_q) begin
        eq_restart_bit_q[1] <= reg_wdata[`DSRCTL_EQ_RESTART];
        eq_override_q[1]    <= reg_wdata[`DSRCTL_EQ_OVERRIDE];
        eq_floor_en_q[1]    <= reg_wdata[`DSRCTL_EQ_FLOOR_EN];
      end
    end
  end

  // block outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      audio_strobe_rising <= 1'b0;
      pclk_from_selftest  <= 1'b0;
      rx_lock             <= 1'b0;
      video_disabled_flag <= 1'b0;
      back_channel_out    <= 1'b0;
      link_input_mode     <= DSRCTL_MODE_AUTO;
    end else begin
      audio_strobe_rising <= rising_q;
      pclk_from_selftest  <= pclk_ext_q;
      rx_lock <= link_linked & (lock_mode_q | ~fwd_video_disabled);
      video_disabled_flag <= fwd_video_disabled;
      back_channel_out <= raw_bc_q ? back_channel_pin_zero
                                   : back_channel_filtered;
      link_input_mode <= dsrctl_mode_e'(mode_q);
    end
  end

  // equalizer outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eq_restart     <= 2'h0;
      eq_floor_apply <= 2'h0;
      eq_floor_p0    <= '0;
      eq_floor_p1    <= '0;
    end else begin
      eq_restart     <= {2{|eq_restart_bit_q}};
      eq_floor_apply <= eq_override_q & eq_floor_en_q;
      eq_floor_p0 <= (eq_override_q[0] & eq_floor_en_q[0]) ?
                     eq_floor_value_p0 : '0;
      eq_floor_p1 <= (eq_override_q[1] & eq_floor_en_q[1]) ?
                     eq_floor_value_p1 : '0;
    end
  end

  // port one wins the read when both are selected
  assign rd_port1 = port_one_select_q;

  // read mux, reserved bits as zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == `DSRCTL_ADDR_AUDIO) begin
      rdata_d[`DSRCTL_AUD_OVERRUN]  = overrun_q;
      rdata_d[`DSRCTL_AUD_UNDERRUN] = underrun_q;
      rdata_d[`DSRCTL_AUD_ERR_CLR]  = err_clr_bit_q;
      rdata_d[`DSRCTL_AUD_RISING]   = rising_q;
    end else if (reg_addr == `DSRCTL_ADDR_PCLK) begin
      rdata_d[`DSRCTL_PCLK_EXT] = pclk_ext_q;
    end else if (reg_addr == `DSRCTL_ADDR_DUALRX) begin
      rdata_d[`DSRCTL_DRX_LOCK_MODE] = lock_mode_q;
      rdata_d[`DSRCTL_DRX_RAW_BC]    = raw_bc_q;
      rdata_d[`DSRCTL_DRX_MODE_HI:`DSRCTL_DRX_MODE_LO] = mode_q;
      rdata_d[`DSRCTL_DRX_PORT1]     = port_one_select_q;
      rdata_d[`DSRCTL_DRX_PORT0]     = port_zero_select_q;
    end else if (reg_addr == `DSRCTL_ADDR_EQ1) begin
      if (rd_port1) begin
        rdata_d = eq1_byte(eq_restart_bit_q[1], eq_override_q[1],
                           eq_floor_en_q[1]);
      end else begin
        rdata_d = eq1_byte(eq_restart_bit_q[0], eq_override_q[0],
                           eq_floor_en_q[0]);
      end
    end else if (reg_addr == `DSRCTL_ADDR_STRAP) begin
      rdata_d[`DSRCTL_ST1_DONE] = st1.done;
      rdata_d[`DSRCTL_ST1_HI:`DSRCTL_ST1_LO] = st1.code;
      rdata_d[`DSRCTL_ST0_DONE] = st0.done;
      rdata_d[`DSRCTL_ST0_HI:`DSRCTL_ST0_LO] = st0.code;
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
      if (reg_read) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  a_overrun_sticky: assert property (
    @(posedge clock) disable iff (!reset_n)
    audio_overrun_event |=> overrun_q)
    else $error("overrun event not recorded");
  a_underrun_clear: assert property (
    @(posedge clock) disable iff (!reset_n)
    err_clear && !audio_underrun_event |=> !underrun_q)
    else $error("underrun not cleared");
  a_lock_mode0: assert property (
    @(posedge clock) disable iff (!reset_n)
    !lock_mode_q && fwd_video_disabled |=> !rx_lock)
    else $error("lock given while video disabled in mode 0");
  a_lock_mode1: assert property (
    @(posedge clock) disable iff (!reset_n)
    lock_mode_q && link_linked |=> rx_lock)
    else $error("lock missing while linked in mode 1");
  a_raw_bc_pass: assert property (
    @(posedge clock) disable iff (!reset_n)
    raw_bc_q |=> back_channel_out == $past(back_channel_pin_zero))
    else $error("raw back channel not passed through");
  a_port1_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    reg_read && reg_addr == `DSRCTL_ADDR_EQ1 && port_one_select_q
    |=> reg_rvalid &&
        reg_rdata[`DSRCTL_EQ_OVERRIDE] == $past(eq_override_q[1]))
    else $error("port one not returned on read");
  a_floor_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    !eq_override_q[0] |=> !eq_floor_apply[0] && eq_floor_p0 == '0)
    else $error("floor applied without override");
  a_restart_both: assert property (
    @(posedge clock) disable iff (!reset_n)
    eq_restart_bit_q[0] |=> eq_restart == 2'h3)
    else $error("restart not given to both ports");
  a_strap_done: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(st1.done) |-> st1.code == $past(strap_one_decode))
    else $error("strap one done without latched code");
endmodule // dsrctl_top

// ---- shared/dsrctl_defs.svh ----
// offsets, field positions, reset values of the control register slice
`ifndef DSRCTL_DEFS_SVH
`define DSRCTL_DEFS_SVH
`define DSRCTL_ADDR_AUDIO     8'h2B
`define DSRCTL_ADDR_PCLK      8'h2E
`define DSRCTL_ADDR_DUALRX    8'h34
`define DSRCTL_ADDR_EQ1       8'h35
`define DSRCTL_ADDR_STRAP     8'h37
`define DSRCTL_AUD_OVERRUN    3
`define DSRCTL_AUD_UNDERRUN   2
`define DSRCTL_AUD_ERR_CLR    1
`define DSRCTL_AUD_RISING     0
`define DSRCTL_PCLK_EXT       7
`define DSRCTL_DRX_LOCK_MODE  6
`define DSRCTL_DRX_RAW_BC     5
`define DSRCTL_DRX_MODE_HI    4
`define DSRCTL_DRX_MODE_LO    3
`define DSRCTL_DRX_PORT1      1
`define DSRCTL_DRX_PORT0      0
`define DSRCTL_EQ_RESTART     6
`define DSRCTL_EQ_OVERRIDE    5
`define DSRCTL_EQ_FLOOR_EN    4
`define DSRCTL_ST1_DONE       7
`define DSRCTL_ST1_HI         6
`define DSRCTL_ST1_LO         4
`define DSRCTL_ST0_DONE       3
`define DSRCTL_ST0_HI         2
`define DSRCTL_ST0_LO         0
`define DSRCTL_RST_AUDIO      8'h00
`define DSRCTL_RST_PCLK       8'h00
`define DSRCTL_RST_DUALRX     8'h01
`define DSRCTL_RST_EQ1        8'h00
`define DSRCTL_RST_STRAP      3'h0
`endif

// ---- shared/dsrctl_pkg.sv ----
// types of the control register slice
package dsrctl_pkg;
  typedef logic [7:0] dsrctl_byte_t;
  typedef logic [2:0] dsrctl_code_t;
  typedef enum logic [1:0] {
    DSRCTL_MODE_AUTO,
    DSRCTL_MODE_DUAL,
    DSRCTL_MODE_PRIMARY,
    DSRCTL_MODE_SECONDARY
  } dsrctl_mode_e;
  typedef enum logic {
    DSRCTL_STRAP_WAIT,
    DSRCTL_STRAP_LATCHED
  } dsrctl_strap_e;
endpackage

// ---- shared/dsrctl_strap_if.sv ----
// carrier between the strap latch and the register bank
`timescale 1ns/1ps
interface dsrctl_strap_if;
  logic [2:0] code;
  logic       done;
  modport latch (output code, output done);
  modport bank  (input code, input done);
endinterface

// ---- core/dsrctl_strap.sv ----
// latch of one strap decode with its done flag
`timescale 1ns/1ps
module dsrctl_strap (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  // decoder result
  input  wire logic                  decode_valid,
  input  wire dsrctl_pkg::dsrctl_code_t decode_code,
  // towards the bank
  dsrctl_strap_if.latch              st
);
  import dsrctl_pkg::*;
  `include "dsrctl_defs.svh"

  dsrctl_strap_e state_q;
  dsrctl_code_t  code_q;

  // first valid decode after reset is latched and held
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= DSRCTL_STRAP_WAIT;
      code_q  <= `DSRCTL_RST_STRAP;
    end else begin
      case (state_q)
        DSRCTL_STRAP_WAIT: begin
          if (decode_valid) begin
            code_q  <= decode_code;
            state_q <= DSRCTL_STRAP_LATCHED;
          end
        end
        default: begin
          state_q <= DSRCTL_STRAP_LATCHED;
        end
      endcase
    end
  end

  assign st.code = code_q;
  assign st.done = (state_q == DSRCTL_STRAP_LATCHED);

  a_strap_done_hold: assert property (
    @(posedge clock) disable iff (!reset_n)
    st.done |=> st.done && $stable(code_q))
    else $error("strap decode changed after latching");
endmodule // dsrctl_strap

// ---- testbench/test_dsrctl_top.sv ----
// self-checking bench of the deserializer control register slice
`timescale 1ns/1ps
`include "dsrctl_defs.svh"
module test_dsrctl_top;
  import dsrctl_pkg::*;
  localparam int         FW = 4;
  localparam logic [7:0] AU = `DSRCTL_ADDR_AUDIO;
  localparam logic [7:0] PC = `DSRCTL_ADDR_PCLK;
  localparam logic [7:0] DR = `DSRCTL_ADDR_DUALRX;
  localparam logic [7:0] EQ = `DSRCTL_ADDR_EQ1;
  localparam logic [7:0] ST = `DSRCTL_ADDR_STRAP;
  logic          clock = 1'b0;
  logic          reset_n = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [7:0]    reg_wdata = 8'h00;
  logic          reg_write = 1'b0;
  logic          reg_read = 1'b0;
  logic [7:0]    reg_rdata;
  logic          reg_rvalid;
  logic          ovr_ev = 1'b0;
  logic          und_ev = 1'b0;
  logic          strobe_rising;
  logic          pclk_sel;
  logic          linked = 1'b0;
  logic          vid_dis = 1'b0;
  logic          rx_lock;
  logic          vid_flag;
  logic          bc_pin = 1'b0;
  logic          bc_filt = 1'b0;
  logic          bc_out;
  dsrctl_mode_e  in_mode;
  logic [FW-1:0] fv0 = 4'h9;
  logic [FW-1:0] fv1 = 4'h6;
  logic [1:0]    eq_rst;
  logic [1:0]    eq_apply;
  logic [FW-1:0] eq_f0;
  logic [FW-1:0] eq_f1;
  logic          s0_v = 1'b0;
  dsrctl_code_t  s0_c = 3'h0;
  logic          s1_v = 1'b0;
  dsrctl_code_t  s1_c = 3'h0;
  int            num_errors = 0;
  int            comparisons = 0;
  int            seed = 5;
  logic [31:0]   r;
  logic [7:0]    w;

  always #2.5 clock = ~clock;

  dsrctl_top #(.FLOOR_W(FW)) dut (
    .clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .audio_overrun_event(ovr_ev), .audio_underrun_event(und_ev),
    .audio_strobe_rising(strobe_rising), .pclk_from_selftest(pclk_sel),
    .link_linked(linked), .fwd_video_disabled(vid_dis),
    .rx_lock(rx_lock), .video_disabled_flag(vid_flag),
    .back_channel_pin_zero(bc_pin), .back_channel_filtered(bc_filt),
    .back_channel_out(bc_out), .link_input_mode(in_mode),
    .eq_floor_value_p0(fv0), .eq_floor_value_p1(fv1),
    .eq_restart(eq_rst), .eq_floor_apply(eq_apply),
    .eq_floor_p0(eq_f0), .eq_floor_p1(eq_f1),
    .strap_zero_valid(s0_v), .strap_zero_decode(s0_c),
    .strap_one_valid(s1_v), .strap_one_decode(s1_c)
  );

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write strobe for one cycle, then one more cycle for derived outputs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    @(negedge clock);
  endtask

  // read strobe for one cycle, answer awaited under a bound
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    int i;
    logic [7:0] d;
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_read = 1'b0;
    d = 8'hXX;
    for (i = 0; i < 4; i++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(negedge clock);
    end
    if (i == 4) begin
      num_errors++;
      $display("MISMATCH t=%0t no answer got=%h exp=%h", $time, d, exp);
      print_verdict();
    end else begin
      chk(d, exp);
    end
  endtask

  task automatic ev(input logic o, input logic u);
    @(negedge clock);
    ovr_ev = o;
    und_ev = u;
    @(negedge clock);
    ovr_ev = 1'b0;
    und_ev = 1'b0;
  endtask

  task automatic strap(input logic v0, input logic v1,
                       input dsrctl_code_t c0, input dsrctl_code_t c1);
    @(negedge clock);
    s0_v = v0;
    s1_v = v1;
    s0_c = c0;
    s1_c = c1;
    @(negedge clock);
    s0_v = 1'b0;
    s1_v = 1'b0;
    s0_c = ~c0;
    s1_c = ~c1;
  endtask

  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    rc(AU, 8'h00);
    rc(PC, 8'h00);
    rc(DR, 8'h01);
    rc(EQ, 8'h00);
    rc(ST, 8'h00);
    rc(8'h36, 8'h00);
    $display("test reset values done");
    ev(1'b1, 1'b0);
    rc(AU, 8'h08);
    ev(1'b0, 1'b1);
    rc(AU, 8'h0C);
    wr(AU, 8'hF2);
    rc(AU, 8'h02);
    ev(1'b1, 1'b0);
    rc(AU, 8'h0A);
    wr(AU, 8'h01);
    rc(AU, 8'h09);
    chk(8'(strobe_rising), 8'h01);
    wr(AU, 8'h06);
    rc(AU, 8'h02);
    chk(8'(strobe_rising), 8'h00);
    ovr_ev = 1'b1;
    wr(AU, 8'h02);
    ovr_ev = 1'b0;
    rc(AU, 8'h0A);
    $display("test audio done");
    wr(PC, 8'hFF);
    rc(PC, 8'h80);
    chk(8'(pclk_sel), 8'h01);
    wr(PC, 8'h7F);
    chk(8'(pclk_sel), 8'h00);
    $display("test pixel clock done");
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      w = {r[15:13], 2'(k), r[10:8]};
      wr(DR, w);
      linked = r[0];
      vid_dis = r[1];
      bc_pin = r[2];
      bc_filt = r[3];
      @(negedge clock);
      chk(8'(rx_lock), 8'(linked & (w[6] | ~vid_dis)));
      chk(8'(vid_flag), 8'(vid_dis));
      chk(8'(bc_out), 8'(w[5] ? bc_pin : bc_filt));
      chk(8'(in_mode), 8'(w[4:3]));
      rc(DR, w & 8'h7B);
    end
    $display("test dual receive done");
    wr(DR, 8'h01);
    wr(EQ, 8'hBF);
    wr(DR, 8'h02);
    rc(EQ, 8'h00);
    wr(EQ, 8'h20);
    wr(DR, 8'h03);
    rc(EQ, 8'h20);
    chk(8'(eq_apply), 8'h01);
    chk(8'(eq_f0), 8'(fv0));
    chk(8'(eq_f1), 8'h00);
    wr(DR, 8'h01);
    rc(EQ, 8'h30);
    wr(DR, 8'h03);
    wr(EQ, 8'h40);
    chk(8'(eq_rst), 8'h03);
    chk(8'(eq_apply), 8'h00);
    wr(DR, 8'h01);
    rc(EQ, 8'h40);
    wr(DR, 8'h02);
    wr(EQ, 8'h00);
    chk(8'(eq_rst), 8'h03);
    wr(DR, 8'h01);
    wr(EQ, 8'h00);
    chk(8'(eq_rst), 8'h00);
    wr(DR, 8'h02);
    wr(EQ, 8'h30);
    chk(8'(eq_apply), 8'h02);
    chk(8'(eq_f1), 8'(fv1));
    $display("test port select done");
    strap(1'b1, 1'b0, 3'h5, 3'h0);
    @(negedge clock);
    rc(ST, 8'h0D);
    strap(1'b1, 1'b1, 3'h2, 3'h3);
    @(negedge clock);
    rc(ST, 8'hBD);
    wr(ST, 8'h42);
    rc(ST, 8'hBD);
    $display("test strap done");
    @(negedge clock);
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    rc(DR, 8'h01);
    rc(ST, 8'h00);
    rc(AU, 8'h00);
    $display("test second reset done");
    print_verdict();
  end
endmodule // test_dsrctl_top
